// File: hdl/rwc_reset_watchdog.sv
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - All six reset sources combine into one registered master system reset.
// - Leaving Sleep sets the sleep-wake flag, bit 3 of reset causes.
// - Leaving Idle, or Sleep, sets the idle-wake flag, bit 2.
// - A brown-out reset sets bit 1 of reset causes.
// - A power-on reset sets bit 0 of reset causes.
// - Flags stay set until software clears them; clearing precedes new detection.
// - Software-reset arm bit is write-only, cleared by hardware, resets zero.
// - Arming is refused unless the system unlock sequence was completed.
// - Reading the software-reset register while armed fires a system reset.
// - Only a 16-bit write of 0x5743 to the key restarts the watchdog.
// - Control bit 15 enables the watchdog, only while the fuse enable is 0.
// - Bits 12-8 read the run postscaler, loaded from fuses at each reset.
// - Bits 7-6 read the run clock select, loaded from fuses at reset.
// - Bits 5-1 read the sleep postscaler, loaded from fuses at reset.
// - Bit 0 is read/write window enable, reset from the window fuse bit.
// - Bits 14-13 are unimplemented and read zero.
module rwc_reset_watchdog
	import rwc_pkg::*;
#(
	parameter int TICK_CYCLES = RWC_WDT_TICK_CYCLES
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire rwc_fuse_t watchdog_fuse_word,
	input wire logic power_on_reset,
	input wire logic external_clear_pin_reset,
	input wire logic brownout_reset_req,
	input wire logic config_mismatch_reset,
	input wire logic sleep_active,
	input wire logic idle_active,
	output logic master_system_reset,
	output logic irq
);

	generate
		if (TICK_CYCLES < 1)
		begin : g_bad_tick
			$error("TICK_CYCLES must be at least 1");
		end
	endgenerate

	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic [RWC_CAUSE_WIDTH-1:0] cause_reg;
	logic [RWC_CAUSE_WIDTH-1:0] cause_next;
	logic sw_arm_reg;
	logic sw_arm_next;
	logic software_reset_source_reg;
	logic watchdog_reset_source_reg;
	logic master_reg;
	rwc_unlock_t unlock_reg;
	rwc_unlock_t unlock_next;
	logic wdt_on_reg;
	logic [4:0] run_postscaler_copy_reg;
	logic [1:0] watchdog_clock_select_copy_reg;
	logic [4:0] sleep_postscaler_copy_reg;
	logic window_mode_enable_reg;
	logic [31:0] tick_cnt_reg;
	logic [31:0] period_cnt_reg;
	logic [RWC_EV_COUNT-1:0] irq_status_reg;
	logic [RWC_EV_COUNT-1:0] irq_status_next;
	logic [RWC_EV_COUNT-1:0] irq_mask_reg;
	logic irq_reg;
	logic sleep_prev_reg;
	logic idle_prev_reg;

	// APB decode: one wait state, the access is handled on its first cycle
	wire access = psel & penable & ~pready_reg;
	wire wr = access & pwrite;
	wire rd = access & ~pwrite;
	wire hit_cause = paddr == RWC_ADDR_RESET_CAUSE;
	wire hit_sw = paddr == RWC_ADDR_SW_RESET;
	wire hit_wdt = paddr == RWC_ADDR_WDT_CONTROL;
	wire hit_unlock = paddr == RWC_ADDR_UNLOCK;
	wire hit_stat = paddr == RWC_ADDR_IRQ_STATUS;
	wire hit_mask = paddr == RWC_ADDR_IRQ_MASK;
	wire hit_any = hit_cause | hit_sw | hit_wdt | hit_unlock | hit_stat | hit_mask;
	wire wr_cause = wr & hit_cause & pstrb[0];
	wire wr_sw = wr & hit_sw & pstrb[0];
	wire wr_unlock = wr & hit_unlock & (pstrb == 4'hf);
	wire wr_stat = wr & hit_stat & pstrb[0];
	wire wr_mask = wr & hit_mask & pstrb[0];
	wire wr_wdt_hi = wr & hit_wdt & pstrb[1];
	wire wr_wdt_lo = wr & hit_wdt & pstrb[0];

	// Power-state exits
	wire sleep_wake = sleep_prev_reg & ~sleep_active;
	wire idle_wake = idle_prev_reg & ~idle_active;

	// Reset-cause flags: hardware set wins over a software clear in the same cycle
	wire [RWC_CAUSE_WIDTH-1:0] cause_set = {
		sleep_wake,
		sleep_wake | idle_wake,
		brownout_reset_req,
		power_on_reset
	};
	wire [RWC_CAUSE_WIDTH-1:0] cause_kept = wr_cause ? (cause_reg & pwdata[RWC_CAUSE_WIDTH-1:0])
		: cause_reg;
	assign cause_next = cause_kept | cause_set;

	// Software reset trigger
	wire sw_unlocked = unlock_reg == RWC_OPEN;
	wire sw_fire = rd & hit_sw & sw_arm_reg;
	wire sw_arm_write = wr_sw & pwdata[RWC_SW_ARM_BIT] & sw_unlocked;
	assign sw_arm_next = sw_fire ? 1'b0 : (sw_arm_reg | sw_arm_write);

	always_comb
	begin
		unlock_next = unlock_reg;
		if (wr_unlock)
		begin
			unique case (unlock_reg)
				RWC_LOCKED, RWC_OPEN:
				begin
					unlock_next = (pwdata == RWC_UNLOCK_FIRST) ? RWC_HALF_OPEN : RWC_LOCKED;
				end
				RWC_HALF_OPEN:
				begin
					unlock_next = (pwdata == RWC_UNLOCK_SECOND) ? RWC_OPEN : RWC_LOCKED;
				end
			endcase
		end
	end

	// Watchdog
	wire wdt_enabled = watchdog_fuse_word.fuse_watchdog_enable | wdt_on_reg;
	wire key_write = wr & hit_wdt & (pstrb == RWC_WDT_KEY_STROBE)
		& (pwdata[RWC_WDT_KEY_LSB +: 16] == RWC_WDT_CLEAR_KEY);
	wire [4:0] active_ps = sleep_active ? sleep_postscaler_copy_reg : run_postscaler_copy_reg;
	wire [31:0] period_limit = 32'h1 << active_ps;
	wire tick = tick_cnt_reg == 32'(TICK_CYCLES - 1);
	wire window_violation = key_write & wdt_enabled & window_mode_enable_reg
		& (period_cnt_reg < (period_limit >> 1));
	wire wdt_expire = wdt_enabled & tick & (period_cnt_reg == period_limit - 32'h1);
	wire wdt_restart = key_write | ~wdt_enabled | master_reg;

	// Combined reset request
	wire master_next = power_on_reset | external_clear_pin_reset | software_reset_source_reg
		| watchdog_reset_source_reg | brownout_reset_req | config_mismatch_reset;

	// Interrupt events
	wire [RWC_EV_COUNT-1:0] irq_events = {
		idle_wake | sleep_wake,
		sleep_wake,
		watchdog_reset_source_reg,
		software_reset_source_reg,
		config_mismatch_reset,
		brownout_reset_req,
		external_clear_pin_reset,
		power_on_reset
	};

	genvar gi;
	generate
		for (gi = 0; gi < RWC_EV_COUNT; gi++)
		begin : g_irq
			assign irq_status_next[gi] = irq_events[gi]
				| (irq_status_reg[gi] & ~(wr_stat & pwdata[gi]));
		end
	endgenerate

	// Read data
	wire [31:0] wdt_read = {
		16'h0000,
		wdt_on_reg,
		2'b00,
		run_postscaler_copy_reg,
		watchdog_clock_select_copy_reg,
		sleep_postscaler_copy_reg,
		window_mode_enable_reg
	};
	wire [31:0] cause_read = {28'h0000000, cause_reg};
	wire [31:0] stat_read = {24'h000000, irq_status_reg};
	wire [31:0] mask_read = {24'h000000, irq_mask_reg};
	wire [31:0] read_mux = hit_cause ? cause_read
		: hit_wdt ? wdt_read
		: hit_stat ? stat_read
		: hit_mask ? mask_read
		: 32'h0000_0000;

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end
		else
		begin
			pready_reg <= access;
			pslverr_reg <= access & ~hit_any;
			prdata_reg <= rd ? read_mux : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			cause_reg <= RWC_CAUSE_RESET;
		end
		else
		begin
			cause_reg <= cause_next;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			sw_arm_reg <= 1'b0;
			unlock_reg <= RWC_LOCKED;
		end
		else
		begin
			sw_arm_reg <= sw_arm_next;
			unlock_reg <= unlock_next;
		end
	end

	// Idle level of both power-state inputs is low, so no false wake after reset
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			sleep_prev_reg <= 1'b0;
			idle_prev_reg <= 1'b0;
		end
		else
		begin
			sleep_prev_reg <= sleep_active;
			idle_prev_reg <= idle_active;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			software_reset_source_reg <= 1'b0;
		end
		else
		begin
			software_reset_source_reg <= sw_fire;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			watchdog_reset_source_reg <= 1'b0;
		end
		else
		begin
			watchdog_reset_source_reg <= wdt_expire | window_violation;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			master_reg <= 1'b0;
		end
		else
		begin
			master_reg <= master_next;
		end
	end

	// Shadow copies reload from fuses at block reset and at every master reset
	always_ff @(posedge clk)
	begin
		if (!reset_n || master_reg)
		begin
			wdt_on_reg <= 1'b0;
			run_postscaler_copy_reg <= watchdog_fuse_word.run_postscaler_fuse;
			watchdog_clock_select_copy_reg <= watchdog_fuse_word.run_clock_select_fuse;
			sleep_postscaler_copy_reg <= watchdog_fuse_word.sleep_postscaler_fuse;
			window_mode_enable_reg <= watchdog_fuse_word.window_disable_fuse;
		end
		else
		begin
			if (wr_wdt_hi)
			begin
				wdt_on_reg <= pwdata[RWC_WDT_ON_BIT];
			end
			if (wr_wdt_lo)
			begin
				window_mode_enable_reg <= pwdata[RWC_WDT_WIN_BIT];
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n || wdt_restart)
		begin
			tick_cnt_reg <= 32'h0000_0000;
			period_cnt_reg <= 32'h0000_0000;
		end
		else
		begin
			tick_cnt_reg <= tick ? 32'h0000_0000 : tick_cnt_reg + 32'h1;
			if (tick)
			begin
				period_cnt_reg <= wdt_expire ? 32'h0000_0000 : period_cnt_reg + 32'h1;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			irq_status_reg <= RWC_IRQ_RESET;
		end
		else
		begin
			irq_status_reg <= irq_status_next;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			irq_mask_reg <= RWC_IRQ_RESET;
		end
		else if (wr_mask)
		begin
			irq_mask_reg <= pwdata[RWC_EV_COUNT-1:0];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			irq_reg <= 1'b0;
		end
		else
		begin
			irq_reg <= |(irq_status_reg & irq_mask_reg);
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign master_system_reset = master_reg;
	assign irq = irq_reg;

endmodule

// File: shared/rwc_pkg.sv
package rwc_pkg;

	// Register byte addresses on the APB
	localparam logic [7:0] RWC_ADDR_RESET_CAUSE = 8'h00;
	localparam logic [7:0] RWC_ADDR_SW_RESET = 8'h04;
	localparam logic [7:0] RWC_ADDR_WDT_CONTROL = 8'h08;
	localparam logic [7:0] RWC_ADDR_UNLOCK = 8'h0c;
	localparam logic [7:0] RWC_ADDR_IRQ_STATUS = 8'h10;
	localparam logic [7:0] RWC_ADDR_IRQ_MASK = 8'h14;

	// Reset-cause flag positions
	localparam int RWC_CAUSE_POR_BIT = 0;
	localparam int RWC_CAUSE_BOR_BIT = 1;
	localparam int RWC_CAUSE_IDLE_BIT = 2;
	localparam int RWC_CAUSE_SLEEP_BIT = 3;
	localparam int RWC_CAUSE_WIDTH = 4;
	localparam logic [3:0] RWC_CAUSE_RESET = 4'h0;

	localparam int RWC_SW_ARM_BIT = 0;

	// Watchdog control layout
	localparam int RWC_WDT_KEY_LSB = 16;
	localparam int RWC_WDT_ON_BIT = 15;
	localparam int RWC_WDT_RUN_PS_LSB = 8;
	localparam int RWC_WDT_CLK_SEL_LSB = 6;
	localparam int RWC_WDT_SLP_PS_LSB = 1;
	localparam int RWC_WDT_WIN_BIT = 0;
	localparam logic [15:0] RWC_WDT_CLEAR_KEY = 16'h5743;
	localparam logic [3:0] RWC_WDT_KEY_STROBE = 4'hc;

	// System unlock words; values are arbitrary
	localparam logic [31:0] RWC_UNLOCK_FIRST = 32'h1c3e_5a70;
	localparam logic [31:0] RWC_UNLOCK_SECOND = 32'he3c1_a58f;

	// Interrupt event positions (status and mask share this layout)
	localparam int RWC_EV_POR = 0;
	localparam int RWC_EV_EXT_CLEAR = 1;
	localparam int RWC_EV_BROWNOUT = 2;
	localparam int RWC_EV_CFG_MISMATCH = 3;
	localparam int RWC_EV_SOFTWARE = 4;
	localparam int RWC_EV_WATCHDOG = 5;
	localparam int RWC_EV_SLEEP_WAKE = 6;
	localparam int RWC_EV_IDLE_WAKE = 7;
	localparam int RWC_EV_COUNT = 8;
	localparam logic [7:0] RWC_IRQ_RESET = 8'h00;

	// Watchdog tick period
	localparam int RWC_CLK_PERIOD_NS = 4;
	localparam int RWC_WDT_TICK_NS = 1000;
	localparam int RWC_WDT_TICK_CYCLES = RWC_WDT_TICK_NS / RWC_CLK_PERIOD_NS;

	typedef struct packed {
		logic fuse_watchdog_enable;
		logic [4:0] run_postscaler_fuse;
		logic [1:0] run_clock_select_fuse;
		logic [4:0] sleep_postscaler_fuse;
		logic window_disable_fuse;
	} rwc_fuse_t;

	typedef enum logic [1:0] {
		RWC_LOCKED,
		RWC_HALF_OPEN,
		RWC_OPEN
	} rwc_unlock_t;

endpackage

// File: testbench/rwc_reset_watchdog_properties.sv
`timescale 1ns/1ps
module rwc_chk
	import rwc_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire rwc_fuse_t watchdog_fuse_word,
	input wire logic power_on_reset,
	input wire logic external_clear_pin_reset,
	input wire logic brownout_reset_req,
	input wire logic config_mismatch_reset,
	input wire logic master_system_reset,
	input wire logic irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire logic rd = pready && !pwrite;
	wire logic req = power_on_reset | external_clear_pin_reset | brownout_reset_req
		| config_mismatch_reset;
	AST_MERGE: assert property (req |=> master_system_reset)
		else $error("request gave no master reset");
	AST_WAIT: assert property (psel && penable && !pready |=> pready)
		else $error("access not answered");
	AST_PULSE: assert property (pready |=> !pready)
		else $error("ready held too long");
	AST_UNMAPPED: assert property (pready && paddr > 8'h14 |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	AST_SW_READ: assert property (rd && paddr == 8'h04 |-> prdata == 32'h0)
		else $error("software reset reads nonzero");
	AST_WDT_ZERO: assert property (rd && paddr == 8'h08
		|-> prdata[31:16] == 16'h0 && prdata[14:13] == 2'b00)
		else $error("watchdog key or gap nonzero");
	AST_WDT_SHADOW: assert property (rd && paddr == 8'h08
		|-> prdata[12:1] == watchdog_fuse_word[12:1])
		else $error("watchdog shadow differs from fuses");
	AST_CAUSE_HI: assert property (rd && paddr == 8'h00 |-> prdata[31:4] == 28'h0)
		else $error("reset cause upper bits set");
	cover property (master_system_reset);
	cover property (irq);
	cover property (pslverr);
endmodule
bind rwc_reset_watchdog rwc_chk u_chk (.*);

// File: testbench/tb.sv
`timescale 1ns/1ps
module tb
	import rwc_pkg::*;
;
	logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdv;
	logic [3:0] pstrb = 4'hf;
	logic [5:0] ev = 6'h0;
	logic pready, pslverr, master_system_reset, irq, eseen;
	rwc_fuse_t fuse = 14'h038b;
	int errors = 0, n_checks = 0, n_msr = 0, m;
	always #2 clk = ~clk;
	always @(posedge clk) if (master_system_reset === 1'b1) n_msr++;
	rwc_reset_watchdog #(.TICK_CYCLES(2)) DUT (
		.clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .watchdog_fuse_word(fuse),
		.power_on_reset(ev[0]), .external_clear_pin_reset(ev[1]),
		.brownout_reset_req(ev[2]), .config_mismatch_reset(ev[3]),
		.sleep_active(ev[4]), .idle_active(ev[5]),
		.master_system_reset(master_system_reset), .irq(irq)
	);
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// One APB transfer; values are sampled as they stood at the ready edge
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
		input logic [3:0] s);
		int i;
		@(posedge clk);
		psel <= 1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1;
		i = 0;
		do
		begin
			@(posedge clk);
			i++;
		end
		while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1)
		begin
			errors++;
			conclude();
		end
		rdv = prdata;
		eseen = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		apb(a, 1'b1, d, s);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(a, 1'b0, 32'h0, 4'h0);
		check(rdv, exp);
	endtask
	task automatic pulse(input logic [5:0] v);
		@(posedge clk);
		ev <= v;
		@(posedge clk);
		ev <= 6'h0;
	endtask
	initial
	begin
		repeat (16) @(posedge clk);
		reset_n <= 1;
		rd(8'h00, 32'h0);
		rd(8'h08, 32'h38b);
		rd(8'h20, 32'h0);
		check(eseen, 1);
		pulse(6'h01);
		rd(8'h00, 32'h1);
		pulse(6'h04);
		rd(8'h00, 32'h3);
		wr(8'h00, 32'h2, 4'hf);
		rd(8'h00, 32'h2);
		wr(8'h00, 32'h0, 4'hf);
		pulse(6'h10);
		rd(8'h00, 32'hc);
		wr(8'h00, 32'h0, 4'hf);
		pulse(6'h20);
		rd(8'h00, 32'h4);
		rd(8'h10, 32'hc5);
		check(irq, 0);
		wr(8'h14, 32'h4, 4'hf);
		repeat (2) @(posedge clk);
		check(irq, 1);
		wr(8'h10, 32'hff, 4'hf);
		repeat (2) @(posedge clk);
		check(irq, 0);
		m = n_msr;
		pulse(6'h0a);
		repeat (2) @(posedge clk);
		check(n_msr, m + 1);
		wr(8'h04, 32'h1, 4'hf);
		rd(8'h04, 32'h0);
		repeat (3) @(posedge clk);
		check(n_msr, m + 1);
		wr(8'h0c, RWC_UNLOCK_FIRST, 4'hf);
		wr(8'h0c, RWC_UNLOCK_SECOND, 4'hf);
		wr(8'h04, 32'h1, 4'hf);
		rd(8'h04, 32'h0);
		repeat (3) @(posedge clk);
		check(n_msr, m + 2);
		rd(8'h04, 32'h0);
		repeat (3) @(posedge clk);
		check(n_msr, m + 2);
		wr(8'h08, 32'h8000, 4'h3);
		rd(8'h08, 32'h838a);
		repeat (8) wr(8'h08, 32'h5743_0000, 4'hc);
		check(n_msr, m + 2);
		repeat (10) wr(8'h08, 32'h5742_0000, 4'hc);
		check(n_msr, m + 3);
		rd(8'h08, 32'h38b);
		fuse.fuse_watchdog_enable <= 1'b1;
		repeat (20) @(posedge clk);
		check(n_msr, m + 4);
		fuse.fuse_watchdog_enable <= 1'b0;
		wr(8'h08, 32'h8000, 4'h3);
		repeat (10) wr(8'h08, 32'h5743_0000, 4'h8);
		check(n_msr, m + 5);
		wr(8'h08, 32'h0, 4'h3);
		conclude();
	end
endmodule
